// file: logic/spg_consts.svh
/*
 * Constants of the sleep port clock gating block: offsets, field positions,
 * reset values and widths.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef SPG_CONSTS_SVH
`define SPG_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SPG_OFF_RUN_EN       12'h108
`define SPG_OFF_SLEEP_EN     12'h118
`define SPG_OFF_DEEP_EN      12'h128
`define SPG_OFF_RUN_CFG      12'h200
`define SPG_OFF_IRQ_STATUS   12'h204
`define SPG_OFF_IRQ_MASK     12'h208
`define SPG_OFF_FAULT_INFO   12'h20c
`define SPG_OFF_ACTIVE_EN    12'h210

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define SPG_ADDR_W           12
`define SPG_DATA_W           32
`define SPG_NUM_PORTS        5
`define SPG_PORT_SEL_W       3
`define SPG_BIT_PORT_A       0
`define SPG_BIT_PORT_B       1
`define SPG_BIT_PORT_C       2
`define SPG_BIT_PORT_D       3
`define SPG_BIT_PORT_E       4
`define SPG_BIT_ACG          0
`define SPG_IRQ_W            2
`define SPG_IRQ_FAULT        0
`define SPG_IRQ_SLEEP_ENTRY  1
`define SPG_FCNT_W           8
`define SPG_FINFO_PORT       0
`define SPG_FINFO_WRITE      3
`define SPG_FINFO_CNT        8

// ----------------------------------------------------------------------------
// Reset values and fault count limits
// ----------------------------------------------------------------------------
`define SPG_RST_EN           5'h00
`define SPG_RST_CFG          1'h0
`define SPG_RST_IRQ          2'h0
`define SPG_RST_DATA         32'h0000_0000
`define SPG_RST_FCNT         8'h00
`define SPG_FCNT_MAX         8'hff
`define SPG_FCNT_ONE         8'h01

`endif

// file: logic/spg_pkg.sv
/*
 * Types shared by the sleep port clock gating block.
 * Assumes spg_consts.svh is on the include path.
 */
`include "spg_consts.svh"

package spg_pkg;

    // ------------------------------------------------------------------------
    // Power modes and carriers
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SPG_MODE_RUN   = 2'b00,
        SPG_MODE_SLEEP = 2'b01,
        SPG_MODE_DEEP  = 2'b10
    } spg_mode_t;

    typedef struct packed {
        logic [`SPG_ADDR_W-1:0] addr;
        logic [`SPG_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } spg_reg_req_t;

    typedef struct packed {
        logic                       valid;
        logic                       write;
        logic [`SPG_PORT_SEL_W-1:0] sel;
    } spg_port_acc_t;

endpackage

// file: logic/spg_gate_cell.sv
/*
 * One port's clock enable flip-flop.
 * Assumes the enable is computed in the clk domain; the downstream clock gate
 * cell of the port samples this registered level.
 */
`include "spg_consts.svh"

module spg_gate_cell
    import spg_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic en_nxt,
    output logic      clk_on
);

    logic clk_on_r;

    // ------------------------------------------------------------------------
    // Enable register
    // ------------------------------------------------------------------------
    // Registering the enable keeps the downstream gate free of decode glitches.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_on_r <= 1'b0;
        end else begin
            clk_on_r <= en_nxt;
        end
    end

    assign clk_on = clk_on_r;

endmodule // spg_gate_cell

// file: logic/spg_sleep_port_clock_gating.sv
/*
 * Sleep port clock gating: run, sleep and deep sleep enable registers for
 * five ports, mode selection, per-port clock enables and bus fault checks.
 * Assumes a single clock, register strobes of one cycle, and that the power
 * mode input and port access requests are synchronous to clk.
 */
// Function
// - A set sleep enable bit clocks its port during sleep.
// - A clear enable bit withholds the port clock, port disabled.
// - Access to a port whose clock is withheld answers with bus fault.
// - All sleep enable bits read zero after reset.
// - Bits 4 to 0 enable ports E, D, C, B and A.
// - Sleep register applies in sleep; run and deep registers elsewhere.
// - Sleep gating registers used only when auto gating select is set.
`include "spg_consts.svh"

module spg_sleep_port_clock_gating
    import spg_pkg::*;
#(
    parameter int NUM_PORTS = `SPG_NUM_PORTS
)
(
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire spg_reg_req_t            reg_req,
    output logic [`SPG_DATA_W-1:0]       reg_rdata,
    input  wire spg_mode_t               pwr_mode,
    input  wire spg_port_acc_t           port_acc,
    output logic [NUM_PORTS-1:0]         port_clk_on,
    output logic                         acc_fault,
    output logic                         acc_ok,
    output logic                         irq
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [NUM_PORTS-1:0]       run_en_r;
    logic [NUM_PORTS-1:0]       run_en_nxt;
    logic [NUM_PORTS-1:0]       sleep_en_r;
    logic [NUM_PORTS-1:0]       sleep_en_nxt;
    logic [NUM_PORTS-1:0]       deep_en_r;
    logic [NUM_PORTS-1:0]       deep_en_nxt;
    logic                       acg_r;
    logic                       acg_nxt;
    logic [`SPG_IRQ_W-1:0]      irq_status_r;
    logic [`SPG_IRQ_W-1:0]      irq_status_nxt;
    logic [`SPG_IRQ_W-1:0]      irq_mask_r;
    logic [`SPG_IRQ_W-1:0]      irq_mask_nxt;
    logic                       irq_r;
    logic                       irq_nxt;
    logic [`SPG_DATA_W-1:0]     rdata_r;
    logic [`SPG_DATA_W-1:0]     rdata_nxt;
    logic                       fault_r;
    logic                       fault_nxt;
    logic                       ok_r;
    logic                       ok_nxt;
    logic [`SPG_PORT_SEL_W-1:0] fault_port_r;
    logic [`SPG_PORT_SEL_W-1:0] fault_port_nxt;
    logic                       fault_write_r;
    logic                       fault_write_nxt;
    logic [`SPG_FCNT_W-1:0]     fault_cnt_r;
    logic [`SPG_FCNT_W-1:0]     fault_cnt_nxt;
    spg_mode_t                  mode_r;
    spg_mode_t                  mode_nxt;
    logic [NUM_PORTS-1:0]       eff_en;
    logic [NUM_PORTS-1:0]       clk_on_w;
    logic [`SPG_IRQ_W-1:0]      irq_event;
    logic                       sel_clocked;
    logic                       sel_valid;

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------
    // Register decode is shared by the write path and the read path.
    function automatic logic hit(input spg_reg_req_t req,
                                 input logic [`SPG_ADDR_W-1:0] off);
        hit = (req.addr == off);
    endfunction

    // Keeps only the enable field of a write word; reserved bits are dropped.
    function automatic logic [NUM_PORTS-1:0] en_field(input logic [`SPG_DATA_W-1:0] d);
        en_field = d[NUM_PORTS-1:0];
    endfunction

    // Places a narrow field in the low bits of a read word.
    function automatic logic [`SPG_DATA_W-1:0] widen(input logic [NUM_PORTS-1:0] v);
        logic [`SPG_DATA_W-1:0] w;
        w = `SPG_RST_DATA;
        w[NUM_PORTS-1:0] = v;
        widen = w;
    endfunction

    // Packs the last fault's port, direction and saturating count for read-back.
    function automatic logic [`SPG_DATA_W-1:0] fault_word(
        input logic [`SPG_PORT_SEL_W-1:0] port,
        input logic                       write,
        input logic [`SPG_FCNT_W-1:0]     cnt
    );
        logic [`SPG_DATA_W-1:0] w;
        w = `SPG_RST_DATA;
        w[`SPG_FINFO_PORT +: `SPG_PORT_SEL_W] = port;
        w[`SPG_FINFO_WRITE]                   = write;
        w[`SPG_FINFO_CNT +: `SPG_FCNT_W]      = cnt;
        fault_word = w;
    endfunction

    // ------------------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------------------
    // Reserved bits of a write are dropped, so their read-back stays zero.
    always_comb begin
        run_en_nxt   = run_en_r;
        sleep_en_nxt = sleep_en_r;
        deep_en_nxt  = deep_en_r;
        acg_nxt      = acg_r;
        irq_mask_nxt = irq_mask_r;
        if (reg_req.wr) begin
            if (hit(reg_req, `SPG_OFF_RUN_EN)) begin
                run_en_nxt = en_field(reg_req.wdata);
            end
            if (hit(reg_req, `SPG_OFF_SLEEP_EN)) begin
                sleep_en_nxt = en_field(reg_req.wdata);
            end
            if (hit(reg_req, `SPG_OFF_DEEP_EN)) begin
                deep_en_nxt = en_field(reg_req.wdata);
            end
            if (hit(reg_req, `SPG_OFF_RUN_CFG)) begin
                acg_nxt = reg_req.wdata[`SPG_BIT_ACG];
            end
            if (hit(reg_req, `SPG_OFF_IRQ_MASK)) begin
                irq_mask_nxt = reg_req.wdata[`SPG_IRQ_W-1:0];
            end
        end
    end

    // Every enable starts clear, so no port runs until software asks for it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_en_r   <= NUM_PORTS'(`SPG_RST_EN);
            sleep_en_r <= NUM_PORTS'(`SPG_RST_EN);
            deep_en_r  <= NUM_PORTS'(`SPG_RST_EN);
            acg_r      <= `SPG_RST_CFG;
            irq_mask_r <= `SPG_RST_IRQ;
        end else begin
            run_en_r   <= run_en_nxt;
            sleep_en_r <= sleep_en_nxt;
            deep_en_r  <= deep_en_nxt;
            acg_r      <= acg_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------------
    // Deep sleep with auto gating off falls back to the run set, as sleep does.
    // Code 2'b11 is not a mode of its own; it is treated as running.
    always_comb begin
        case (pwr_mode)
            SPG_MODE_RUN: begin
                eff_en = run_en_r;
            end
            SPG_MODE_SLEEP: begin
                if (acg_r) begin
                    eff_en = sleep_en_r;
                end else begin
                    eff_en = run_en_r;
                end
            end
            SPG_MODE_DEEP: begin
                if (acg_r) begin
                    eff_en = deep_en_r;
                end else begin
                    eff_en = run_en_r;
                end
            end
            default: begin
                eff_en = run_en_r;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Per-port clock enables
    // ------------------------------------------------------------------------
    // A set enable delivers the port clock; a clear one holds it stopped.
    // Registering the enables costs one cycle after a write or a mode change;
    // software must allow for it before it touches a newly enabled port.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
            spg_gate_cell u_cell (
                .clk    (clk),
                .rst_b  (rst_b),
                .en_nxt (eff_en[gi]),
                .clk_on (clk_on_w[gi])
            );
        end
    endgenerate

    assign port_clk_on = clk_on_w;

    // ------------------------------------------------------------------------
    // Port access check
    // ------------------------------------------------------------------------
    // The check uses the enable already delivered, not the one about to be,
    // so an access never lands on a port whose clock is still stopped.
    always_comb begin
        sel_valid   = (32'(port_acc.sel) < NUM_PORTS);
        sel_clocked = 1'b0;
        if (sel_valid) begin
            sel_clocked = clk_on_w[port_acc.sel];
        end
    end

    // The fault count saturates instead of wrapping, so a burst of bad
    // accesses never reads back as a small number.
    always_comb begin
        fault_nxt       = 1'b0;
        ok_nxt          = 1'b0;
        fault_port_nxt  = fault_port_r;
        fault_write_nxt = fault_write_r;
        fault_cnt_nxt   = fault_cnt_r;
        if (port_acc.valid) begin
            if (sel_clocked) begin
                ok_nxt = 1'b1;
            end else begin
                fault_nxt       = 1'b1;
                fault_port_nxt  = port_acc.sel;
                fault_write_nxt = port_acc.write;
                if (fault_cnt_r != `SPG_FCNT_MAX) begin
                    fault_cnt_nxt = fault_cnt_r + `SPG_FCNT_ONE;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_r       <= 1'b0;
            ok_r          <= 1'b0;
            fault_port_r  <= '0;
            fault_write_r <= 1'b0;
            fault_cnt_r   <= `SPG_RST_FCNT;
        end else begin
            fault_r       <= fault_nxt;
            ok_r          <= ok_nxt;
            fault_port_r  <= fault_port_nxt;
            fault_write_r <= fault_write_nxt;
            fault_cnt_r   <= fault_cnt_nxt;
        end
    end

    assign acc_fault = fault_r;
    assign acc_ok    = ok_r;

    // ------------------------------------------------------------------------
    // Interrupt status and output
    // ------------------------------------------------------------------------
    // Only the step into sleep raises the sleep entry event, so the mode is kept a cycle.
    always_comb begin
        mode_nxt = pwr_mode;
    end

    always_comb begin
        irq_event = '0;
        irq_event[`SPG_IRQ_FAULT]       = fault_nxt;
        irq_event[`SPG_IRQ_SLEEP_ENTRY] = (pwr_mode == SPG_MODE_SLEEP) &&
                                          (mode_r != SPG_MODE_SLEEP) && acg_r;
    end

    // A new event in the clearing cycle wins, so no event is ever lost.
    always_comb begin
        irq_status_nxt = irq_status_r;
        if (reg_req.wr && hit(reg_req, `SPG_OFF_IRQ_STATUS)) begin
            irq_status_nxt = irq_status_r & ~reg_req.wdata[`SPG_IRQ_W-1:0];
        end
        irq_status_nxt = irq_status_nxt | irq_event;
        irq_nxt        = |(irq_status_nxt & irq_mask_nxt);
    end

    // The output is registered from next values, so it follows the status bit
    // in the same cycle rather than one cycle later.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status_r <= `SPG_RST_IRQ;
            irq_r        <= 1'b0;
            mode_r       <= SPG_MODE_RUN;
        end else begin
            irq_status_r <= irq_status_nxt;
            irq_r        <= irq_nxt;
            mode_r       <= mode_nxt;
        end
    end

    assign irq = irq_r;

    // ------------------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------------------
    // Read data stand only in the cycle after the strobe; unmapped reads give
    // zero, which is also what reserved bits show.
    always_comb begin
        rdata_nxt = `SPG_RST_DATA;
        if (reg_req.rd) begin
            if (hit(reg_req, `SPG_OFF_RUN_EN)) begin
                rdata_nxt = widen(run_en_r);
            end else if (hit(reg_req, `SPG_OFF_SLEEP_EN)) begin
                rdata_nxt = widen(sleep_en_r);
            end else if (hit(reg_req, `SPG_OFF_DEEP_EN)) begin
                rdata_nxt = widen(deep_en_r);
            end else if (hit(reg_req, `SPG_OFF_RUN_CFG)) begin
                rdata_nxt[`SPG_BIT_ACG] = acg_r;
            end else if (hit(reg_req, `SPG_OFF_IRQ_STATUS)) begin
                rdata_nxt[`SPG_IRQ_W-1:0] = irq_status_r;
            end else if (hit(reg_req, `SPG_OFF_IRQ_MASK)) begin
                rdata_nxt[`SPG_IRQ_W-1:0] = irq_mask_r;
            end else if (hit(reg_req, `SPG_OFF_FAULT_INFO)) begin
                rdata_nxt = fault_word(fault_port_r, fault_write_r, fault_cnt_r);
            end else if (hit(reg_req, `SPG_OFF_ACTIVE_EN)) begin
                rdata_nxt = widen(clk_on_w);
            end else begin
                rdata_nxt = `SPG_RST_DATA;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= `SPG_RST_DATA;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

endmodule // spg_sleep_port_clock_gating

// file: tb/spg_chk.sv
/*
 * Port checker of the sleep port clock gating block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`include "spg_consts.svh"

module spg_chk
    import spg_pkg::*;
#(
    parameter int NUM_PORTS = `SPG_NUM_PORTS
)
(
    input wire logic                   clk,
    input wire logic                   rst_b,
    input wire spg_reg_req_t           reg_req,
    input wire logic [`SPG_DATA_W-1:0] reg_rdata,
    input wire spg_mode_t              pwr_mode,
    input wire spg_port_acc_t          port_acc,
    input wire logic [NUM_PORTS-1:0]   port_clk_on,
    input wire logic                   acc_fault,
    input wire logic                   acc_ok,
    input wire logic                   irq
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Shadow of the auto gating select, so the checker knows which set applies.
    logic       acg_r;
    logic       acg_nxt;
    logic [7:0] on8;
    logic       gated;

    always_comb begin
        acg_nxt = acg_r;
        if (reg_req.wr && reg_req.addr == `SPG_OFF_RUN_CFG) begin
            acg_nxt = reg_req.wdata[`SPG_BIT_ACG];
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acg_r <= 1'b0;
        end else begin
            acg_r <= acg_nxt;
        end
    end
    // Widened so that selectors above the last port index a zero, not an unknown.
    assign on8   = 8'(port_clk_on);
    assign gated = !on8[port_acc.sel];

    chk_fault_when_gated: assert property (port_acc.valid && gated |=> acc_fault && !acc_ok)
        else $error("gated access not faulted");
    chk_ok_when_clocked: assert property (port_acc.valid && !gated |=> acc_ok && !acc_fault)
        else $error("clocked access not answered");
    chk_quiet_when_idle: assert property (!port_acc.valid |=> !acc_fault && !acc_ok)
        else $error("answer without access");
    chk_rdata_idle_zero: assert property (!reg_req.rd |=> reg_rdata == '0)
        else $error("read data outside read cycle");
    chk_reserved_read_zero: assert property (reg_req.rd && reg_req.addr == `SPG_OFF_SLEEP_EN
        |=> reg_rdata[31:5] == 27'h0)
        else $error("reserved bits not zero");
    chk_run_write_apply: assert property ((reg_req.wr && reg_req.addr == `SPG_OFF_RUN_EN
        && pwr_mode == SPG_MODE_RUN) ##1 (pwr_mode == SPG_MODE_RUN && !reg_req.wr)
        |=> port_clk_on == $past(reg_req.wdata[NUM_PORTS-1:0], 2))
        else $error("run enables not applied");
    chk_sleep_write_apply: assert property ((reg_req.wr && reg_req.addr == `SPG_OFF_SLEEP_EN
        && pwr_mode == SPG_MODE_SLEEP && acg_r) ##1 (pwr_mode == SPG_MODE_SLEEP && !reg_req.wr)
        |=> port_clk_on == $past(reg_req.wdata[NUM_PORTS-1:0], 2))
        else $error("sleep enables not applied");
    chk_acg_off_steady: assert property ((!reg_req.wr && !acg_r) [*2] |=> $stable(port_clk_on))
        else $error("enables moved without run write");
endmodule // spg_chk

bind spg_sleep_port_clock_gating spg_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (
    .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .pwr_mode(pwr_mode), .port_acc(port_acc), .port_clk_on(port_clk_on),
    .acc_fault(acc_fault), .acc_ok(acc_ok), .irq(irq)
);

// file: tb/spg_port_model.sv
/*
 * Bus side of the gated ports: issues one access and returns the answer.
 * Assumes one clock and the answer one cycle after the access.
 */
module spg_port_model
    import spg_pkg::*;
(
    input  wire logic     clk,
    output spg_port_acc_t port_acc,
    input  wire logic     acc_fault,
    input  wire logic     acc_ok
);
    timeunit 1ns;
    timeprecision 1ps;

    initial port_acc = '0;

    // Idle qualifiers are inverted so a stale selector is never mistaken for a held one.
    task automatic access(input logic [2:0] sel, input logic wr, output logic [1:0] ans);
        @(posedge clk);
        port_acc <= '{valid: 1'b1, write: wr, sel: sel};
        @(posedge clk);
        port_acc <= '{valid: 1'b0, write: ~wr, sel: ~sel};
        #1 ans = {acc_fault, acc_ok};
    endtask
endmodule // spg_port_model

// file: tb/spg_sleep_port_clock_gating_tb.sv
/*
 * Self-checking bench of the sleep port clock gating block.
 * Assumes the checker is bound and the port model stands on the access side.
 */
`include "spg_consts.svh"

module spg_sleep_port_clock_gating_tb
    import spg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          clk;
    logic          rst_b;
    spg_reg_req_t  reg_req;
    logic [31:0]   reg_rdata;
    spg_mode_t     pwr_mode;
    spg_port_acc_t port_acc;
    logic [4:0]    port_clk_on;
    logic          acc_fault;
    logic          acc_ok;
    logic          irq;
    int            fail_count;
    int            checks;
    int            cyc;
    int            k;
    logic [31:0]   seed;
    logic [31:0]   d;
    logic [1:0]    ans;
    logic          auto_clock_gating_select;
    logic [4:0]    en [3];
    logic [11:0]   eoff [3] = '{`SPG_OFF_RUN_EN, `SPG_OFF_SLEEP_EN, `SPG_OFF_DEEP_EN};
    logic [11:0]   offs [8] = '{12'h108, 12'h118, 12'h128, 12'h200,
                                12'h204, 12'h208, 12'h20c, 12'h210};

    spg_sleep_port_clock_gating dut (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .pwr_mode(pwr_mode), .port_acc(port_acc),
        .port_clk_on(port_clk_on), .acc_fault(acc_fault), .acc_ok(acc_ok), .irq(irq));
    spg_port_model u_port (.clk(clk), .port_acc(port_acc), .acc_fault(acc_fault),
        .acc_ok(acc_ok));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [4:0] exp_eff();
        if (auto_clock_gating_select && pwr_mode == SPG_MODE_SLEEP) return en[1];
        if (auto_clock_gating_select && pwr_mode == SPG_MODE_DEEP) return en[2];
        return en[0];
    endfunction

    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, output logic [31:0] got);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: reg_req.wdata, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        #1 got = reg_rdata;
        check(got, exp);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic sweep();
        settle();
        check(port_clk_on, exp_eff());
        rd_chk(`SPG_OFF_ACTIVE_EN, exp_eff(), d);
        for (int s = 0; s < 8; s++) begin
            u_port.access(s[2:0], s[1], ans);
            check(ans, (s < 5 && exp_eff() >> s & 1) ? 2'b01 : 2'b10);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        rst_b = 1'b0;
        reg_req = '0;
        pwr_mode = SPG_MODE_RUN;
        seed = 32'h1bd7;
        auto_clock_gating_select = 1'b0;
        en = '{default: 5'h00};
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        foreach (offs[i]) rd_chk(offs[i], 32'h0, d);
        rd_chk(12'h300, 32'h0, d);
        sweep();
        rd_chk(`SPG_OFF_FAULT_INFO, 32'h0000_080f, d);
        // ----------------------------------------------------------------
        // Random enables, gating select and modes
        // ----------------------------------------------------------------
        for (int i = 0; i < 30; i++) begin
            k = i % 3;
            wr_reg(eoff[k], rnd());
            en[k] = seed[4:0];
            rd_chk(eoff[k], {27'h0, en[k]}, d);
            wr_reg(eoff[k], d ^ 32'h1);
            en[k][0] = ~en[k][0];
            if (k == 0) begin
                auto_clock_gating_select = rnd() >> 7 & 1;
                wr_reg(`SPG_OFF_RUN_CFG, {31'h0, auto_clock_gating_select});
            end
            @(posedge clk);
            pwr_mode <= spg_mode_t'(2'(rnd()));
            sweep();
        end
        // ----------------------------------------------------------------
        // Interrupts: masked and unmasked fault, sleep entry
        // ----------------------------------------------------------------
        @(posedge clk);
        pwr_mode <= SPG_MODE_RUN;
        wr_reg(`SPG_OFF_RUN_EN, 32'h0);
        en[0] = 5'h00;
        wr_reg(`SPG_OFF_IRQ_MASK, 32'h1);
        wr_reg(`SPG_OFF_IRQ_STATUS, 32'h3);
        settle();
        check(irq, 1'b0);
        u_port.access(3'h0, 1'b0, ans);
        check(irq, 1'b1);
        rd_chk(`SPG_OFF_IRQ_STATUS, 32'h1, d);
        wr_reg(`SPG_OFF_IRQ_MASK, 32'h2);
        settle();
        check(irq, 1'b0);
        wr_reg(`SPG_OFF_IRQ_STATUS, 32'h1);
        wr_reg(`SPG_OFF_RUN_CFG, 32'h1);
        auto_clock_gating_select = 1'b1;
        @(posedge clk);
        pwr_mode <= SPG_MODE_SLEEP;
        settle();
        check(irq, 1'b1);
        rd_chk(`SPG_OFF_IRQ_STATUS, 32'h2, d);
        sweep();
        // ----------------------------------------------------------------
        // Reset in mid-run
        // ----------------------------------------------------------------
        wr_reg(`SPG_OFF_SLEEP_EN, 32'h1f);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check(port_clk_on, 5'h00);
        check(irq, 1'b0);
        rst_b <= 1'b1;
        auto_clock_gating_select = 1'b0;
        en = '{default: 5'h00};
        rd_chk(`SPG_OFF_SLEEP_EN, 32'h0, d);
        sweep();
        end_of_test();
    end
endmodule // spg_sleep_port_clock_gating_tb
